/* File: rtl/rlc_ladder_decode.sv */
// Decode of stored configuration into analog switch controls.
// Assumes registered inputs; outputs are pure decode of them.
`timescale 1ns/100ps
module rlc_ladder_decode (
  // Configuration
  input  wire rlc_pkg::rlc_ctl_type      ctl,
  input  wire logic [rlc_pkg::LEVEL_W-1:0] level,
  // Analog controls
  output rlc_pkg::rlc_ana_type           ana
);

  // ------------------------------------------------------------
  // Source connection
  // ------------------------------------------------------------
  wire on_w  = ctl.converter_on;
  wire lps_w = ctl.low_power_source_sel;
  wire pos_w = on_w | lps_w;
  wire neg_w = on_w | ~lps_w;

  assign ana.ladder_power = on_w;
  assign ana.pos_connect  = pos_w;
  assign ana.neg_connect  = neg_w;

  // positive source decode
  // Reserved code closes no switch
  assign ana.pos_sel[0] = pos_w & (ctl.positive_source_sel == rlc_pkg::PSS_SUPPLY);
  assign ana.pos_sel[1] = pos_w & (ctl.positive_source_sel == rlc_pkg::PSS_REFPIN);
  assign ana.pos_sel[2] = pos_w & (ctl.positive_source_sel == rlc_pkg::PSS_FIXED);

  assign ana.neg_sel_pin = neg_w & ctl.negative_source_sel;
  assign ana.neg_sel_gnd = neg_w & ~ctl.negative_source_sel;

  assign ana.clamp_pos = ~on_w & lps_w & (level == rlc_pkg::LEVEL_MAX);
  assign ana.clamp_neg = ~on_w & ~lps_w & (level == rlc_pkg::LEVEL_MIN);

  assign ana.pin_route = ctl.pin_drive_enable;

  // ------------------------------------------------------------
  // Tap select
  // ------------------------------------------------------------
  // one of 32 taps while converter_on is set, none when it is clear
  genvar gi;
  generate
    for (gi = 0; gi < rlc_pkg::TAPS; gi++) begin : g_tap
      assign ana.tap_sel[gi] = on_w & (level == rlc_pkg::LEVEL_W'(gi));
    end
  endgenerate

endmodule

/* File: rtl/rlc_pkg.sv */
// Constants and carrier types for the reference ladder control block.
// Assumes a 32-bit APB slave port and one 100 MHz clock.
package rlc_pkg;

  // ------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------
  localparam int          APB_AW      = 12;
  localparam logic [11:0] CONTROL_OFS = 12'h000;
  localparam logic [11:0] LEVEL_OFS   = 12'h004;
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  LEVEL_RST   = 8'h00;
  // Implemented bits: 7,6,5,3,2,0
  localparam logic [7:0]  CONTROL_MSK = 8'hED;
  localparam logic [7:0]  LEVEL_MSK   = 8'h1F;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ON_BIT  = 7;
  localparam int LPS_BIT = 6;
  localparam int OE_BIT  = 5;
  localparam int PSS_LSB = 2;
  localparam int NSS_BIT = 0;
  localparam int LEVEL_W = 5;
  localparam int TAPS    = 32;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] PSS_SUPPLY = 2'h0;
  localparam logic [1:0] PSS_REFPIN = 2'h1;
  localparam logic [1:0] PSS_FIXED  = 2'h2;
  localparam logic [1:0] PSS_RSVD   = 2'h3;
  localparam logic [4:0] LEVEL_MAX  = 5'h1F;
  localparam logic [4:0] LEVEL_MIN  = 5'h00;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       converter_on;
    logic       low_power_source_sel;
    logic       pin_drive_enable;
    logic [1:0] positive_source_sel;
    logic       negative_source_sel;
  } rlc_ctl_type;

  typedef struct packed {
    logic            ladder_power;
    logic            pos_connect;
    logic            neg_connect;
    logic [2:0]      pos_sel;
    logic            neg_sel_pin;
    logic            neg_sel_gnd;
    logic            clamp_pos;
    logic            clamp_neg;
    logic            pin_route;
    logic [TAPS-1:0] tap_sel;
  } rlc_ana_type;

endpackage

/* File: rtl/rlc_top.sv */
// Reference ladder control: APB register file, pad override, decode.
// Assumes pad_in is asynchronous; port_* and sleep_active are on clock.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
module rlc_top (
  // Clock and reset
  input  wire  logic        clock,
  input  wire  logic        resetn,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  input  wire  logic [3:0]  pstrb,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Port logic side of the output pin
  input  wire  logic        port_out,
  input  wire  logic        port_oe_n,
  output logic              port_read,
  // Pad side of the output pin
  input  wire  logic        pad_in,
  output logic              pad_out,
  output logic              pad_oe_n,
  // System state
  input  wire  logic        sleep_active,
  // Analog controls
  output rlc_pkg::rlc_ana_type ana
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  rlc_pkg::rlc_ctl_type ctl_q;
  rlc_pkg::rlc_ctl_type ctl_d;
  logic [4:0]           level_q;
  logic [4:0]           level_d;
  logic [31:0]          prdata_q;
  logic [31:0]          prdata_d;
  logic                 sync1_q;
  logic                 sync2_q;
  logic                 pin_read_q;
  logic                 pad_out_q;
  logic                 pad_oe_n_q;

  // Reset image of the control fields, held as a constant for the reset branch
  localparam rlc_pkg::rlc_ctl_type CTL_RST = '{
    converter_on:         rlc_pkg::CONTROL_RST[rlc_pkg::ON_BIT],
    low_power_source_sel: rlc_pkg::CONTROL_RST[rlc_pkg::LPS_BIT],
    pin_drive_enable:     rlc_pkg::CONTROL_RST[rlc_pkg::OE_BIT],
    positive_source_sel:  rlc_pkg::CONTROL_RST[rlc_pkg::PSS_LSB+:2],
    negative_source_sel:  rlc_pkg::CONTROL_RST[rlc_pkg::NSS_BIT]
  };

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire       setup_w  = psel & ~penable;
  wire       access_w = psel & penable;
  wire       hit_ctl  = (paddr == rlc_pkg::CONTROL_OFS);
  wire       hit_lvl  = (paddr == rlc_pkg::LEVEL_OFS);
  wire       hit_any  = hit_ctl | hit_lvl;
  wire       lane0_w  = pstrb[0];
  wire       wr_ctl   = access_w & pwrite & hit_ctl & lane0_w;
  wire       wr_lvl   = access_w & pwrite & hit_lvl & lane0_w;
  wire       rd_setup = setup_w & ~pwrite;

  // Zero wait states; data was loaded in setup
  assign pready  = 1'b1;
  assign pslverr = access_w & ~hit_any;
  assign prdata  = prdata_q;

  // ------------------------------------------------------------
  // Register images
  // ------------------------------------------------------------
  // unimplemented bits read zero
  wire [7:0] ctl_img = {ctl_q.converter_on,
                        ctl_q.low_power_source_sel,
                        ctl_q.pin_drive_enable,
                        1'b0,
                        ctl_q.positive_source_sel,
                        1'b0,
                        ctl_q.negative_source_sel};
  wire [7:0] lvl_img = {3'h0, level_q};

  wire [7:0] rd_byte = hit_ctl ? ctl_img :
                       hit_lvl ? lvl_img : 8'h00;

  // ------------------------------------------------------------
  // Next-state decode
  // ------------------------------------------------------------
  // write stores implemented bits
  wire [7:0] wctl_w = pwdata[7:0] & rlc_pkg::CONTROL_MSK;

  assign ctl_d = wr_ctl ?
    '{converter_on:         wctl_w[rlc_pkg::ON_BIT],
      low_power_source_sel: wctl_w[rlc_pkg::LPS_BIT],
      pin_drive_enable:     wctl_w[rlc_pkg::OE_BIT],
      positive_source_sel:  wctl_w[rlc_pkg::PSS_LSB+:2],
      negative_source_sel:  wctl_w[rlc_pkg::NSS_BIT]} : ctl_q;

  wire [7:0] wlvl_w = pwdata[7:0] & rlc_pkg::LEVEL_MSK;
  assign level_d = wr_lvl ? wlvl_w[rlc_pkg::LEVEL_W-1:0] : level_q;

  assign prdata_d = rd_setup ? {24'h000000, rd_byte} : prdata_q;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // reset clears control and level
  // no path but writes alters them
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl_q   <= CTL_RST;
      level_q <= rlc_pkg::LEVEL_RST[4:0];
    end else begin
      ctl_q   <= ctl_d;
      level_q <= level_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ------------------------------------------------------------
  // Pad input synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  // ------------------------------------------------------------
  // Pad override
  // ------------------------------------------------------------
  wire route_w    = ctl_q.pin_drive_enable;
  wire read_d     = route_w ? 1'b0 : sync2_q;
  wire pad_oe_n_d = route_w | port_oe_n;
  wire pad_out_d  = route_w ? 1'b0 : port_out;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_read_q <= 1'b0;
      pad_out_q  <= 1'b0;
      pad_oe_n_q <= 1'b1;
    end else begin
      pin_read_q <= read_d;
      pad_out_q  <= pad_out_d;
      pad_oe_n_q <= pad_oe_n_d;
    end
  end

  assign port_read = pin_read_q;
  assign pad_out   = pad_out_q;
  assign pad_oe_n  = pad_oe_n_q;

  // ------------------------------------------------------------
  // Analog decode
  // ------------------------------------------------------------
  rlc_ladder_decode rlc_ladder_decode_i (
    .ctl   (ctl_q),
    .level (level_q),
    .ana   (ana)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic first_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first_q <= 1'b0;
    end else begin
      first_q <= 1'b1;
    end
  end

  property p_route_pad;
    @(posedge clock) disable iff (!resetn)
      ctl_q.pin_drive_enable |-> ana.pin_route ##1 (pad_oe_n && !pad_out);
  endproperty
  a_route_pad: assert property (p_route_pad)
    else $error("pad driven while routed");

  property p_read_zero;
    @(posedge clock) disable iff (!resetn)
      ctl_q.pin_drive_enable |=> !port_read;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("routed pin read not zero");

  property p_low_power;
    @(posedge clock) disable iff (!resetn)
      !ctl_q.converter_on |->
        (ana.pos_connect == ctl_q.low_power_source_sel) &&
        (ana.neg_connect == !ctl_q.low_power_source_sel);
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("wrong source dropped");

  property p_clamp_pos;
    @(posedge clock) disable iff (!resetn)
      ana.clamp_pos <->
        (!ctl_q.converter_on && ctl_q.low_power_source_sel &&
         level_q == rlc_pkg::LEVEL_MAX);
  endproperty
  a_clamp_pos: assert property (p_clamp_pos)
    else $error("positive clamp wrong");

  property p_clamp_neg;
    @(posedge clock) disable iff (!resetn)
      ana.clamp_neg <->
        (!ctl_q.converter_on && !ctl_q.low_power_source_sel &&
         level_q == rlc_pkg::LEVEL_MIN);
  endproperty
  a_clamp_neg: assert property (p_clamp_neg)
    else $error("negative clamp wrong");

  property p_sleep_hold;
    @(posedge clock) disable iff (!resetn)
      (sleep_active && !wr_ctl) ##1 !sleep_active |-> $stable(ctl_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("control changed across wake");

  property p_reset_clear;
    @(posedge clock) disable iff (!resetn)
      !first_q |-> ctl_q == 6'h00 && level_q == 5'h00 && pad_oe_n;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  property p_enable;
    @(posedge clock) disable iff (!resetn)
      ana.ladder_power == ctl_q.converter_on;
  endproperty
  a_enable: assert property (p_enable)
    else $error("ladder power mismatch");

  property p_pos_fixed;
    @(posedge clock) disable iff (!resetn)
      ana.pos_connect |->
        (ctl_q.positive_source_sel == rlc_pkg::PSS_FIXED) == (ana.pos_sel == 3'h4);
  endproperty
  a_pos_fixed: assert property (p_pos_fixed)
    else $error("fixed reference select wrong");

  property p_neg_sel;
    @(posedge clock) disable iff (!resetn)
      ana.neg_connect |->
        ana.neg_sel_pin == ctl_q.negative_source_sel &&
        ana.neg_sel_gnd != ctl_q.negative_source_sel;
  endproperty
  a_neg_sel: assert property (p_neg_sel)
    else $error("negative select wrong");

  property p_level_read;
    @(posedge clock) disable iff (!resetn)
      rd_setup && hit_lvl |=> prdata[31:5] == 27'h0 && prdata[4:0] == level_q;
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("level read wrong");

  property p_ctl_read;
    @(posedge clock) disable iff (!resetn)
      rd_setup && hit_ctl |=> !prdata[4] && !prdata[1] && prdata[31:8] == 24'h0;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("unimplemented bits read set");

  property p_tap;
    @(posedge clock) disable iff (!resetn)
      ctl_q.converter_on |-> ana.tap_sel == (32'h00000001 << level_q);
  endproperty
  a_tap: assert property (p_tap)
    else $error("tap select not one-hot on code");

  property p_write_back;
    @(posedge clock) disable iff (!resetn)
      wr_ctl |=> ctl_img == ($past(pwdata[7:0]) & rlc_pkg::CONTROL_MSK);
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("control write not stored");

  property p_rsvd_kept;
    @(posedge clock) disable iff (!resetn)
      wr_ctl && pwdata[3:2] == rlc_pkg::PSS_RSVD |=>
        ctl_q.positive_source_sel == rlc_pkg::PSS_RSVD && ana.pos_sel == 3'h0;
  endproperty
  a_rsvd_kept: assert property (p_rsvd_kept)
    else $error("reserved code not kept");

  property p_level_write;
    @(posedge clock) disable iff (!resetn)
      wr_lvl |=> level_q == $past(pwdata[4:0]);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("level write not stored");

  property p_strobe_off;
    @(posedge clock) disable iff (!resetn)
      access_w && pwrite && !pstrb[0] |=> $stable(ctl_q) && $stable(level_q);
  endproperty
  a_strobe_off: assert property (p_strobe_off)
    else $error("write without low lane changed state");

  property p_unmapped;
    @(posedge clock) disable iff (!resetn)
      access_w && !hit_any |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

endmodule

/* File: verif/rlc_top_bench.sv */
// Self-checking bench for the reference ladder control block.
// Assumes the rlc_pkg package and rlc_top are compiled first.
`timescale 1ns/100ps
module rlc_top_bench;

  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  logic                 clock;
  logic                 resetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [3:0]           pstrb;
  logic                 pready;
  logic [31:0]          prdata;
  logic                 pslverr;
  logic                 port_out;
  logic                 port_oe_n;
  logic                 port_read;
  logic                 pad_in;
  logic                 pad_out;
  logic                 pad_oe_n;
  logic                 sleep_active;
  rlc_pkg::rlc_ana_type ana;
  int                   failures;
  int                   check_count;
  int                   cycles;
  logic [31:0]          rdat;
  logic                 rerr;

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

  rlc_top rlc_top_i (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_out(port_out), .port_oe_n(port_oe_n),
    .port_read(port_read), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .sleep_active(sleep_active), .ana(ana)
  );

  always #5 clock = ~clock;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // APB master
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, 4'hF);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000, 4'hF);
    `CHK("read data", {24'h000000, exp}, rdat)
    `CHK("read error", 1'b0, rerr)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; pstrb = 4'h0; port_out = 1'b1;
    port_oe_n = 1'b0; pad_in = 1'b1; sleep_active = 1'b0;
    failures = 0; check_count = 0; cycles = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    // Reset state and read-only zero bits
    rd(rlc_pkg::CONTROL_OFS, 8'h00);
    rd(rlc_pkg::LEVEL_OFS, 8'h00);
    wr(rlc_pkg::CONTROL_OFS, 8'hFF);
    rd(rlc_pkg::CONTROL_OFS, 8'hED);
    wr(rlc_pkg::LEVEL_OFS, 8'hFF);
    rd(rlc_pkg::LEVEL_OFS, 8'h1F);
    // Refused accesses leave registers alone
    apb(1'b1, 12'h008, 32'h00000000, 4'hF);
    `CHK("unmapped write error", 1'b1, rerr)
    apb(1'b0, 12'h008, 32'h00000000, 4'hF);
    `CHK("unmapped read data", 32'h00000000, rdat)
    apb(1'b1, rlc_pkg::CONTROL_OFS, 32'h00000000, 4'h0);
    rd(rlc_pkg::CONTROL_OFS, 8'hED);
    // Enable bit, positive and negative source fields
    for (int k = 0; k < 3; k++) begin
      wr(rlc_pkg::CONTROL_OFS, 8'h80 | 8'(k << 2));
      `CHK("power on", 1'b1, ana.ladder_power)
      `CHK("positive select", 3'h1 << k, ana.pos_sel)
      `CHK("negative to ground", 1'b1, ana.neg_sel_gnd)
    end
    wr(rlc_pkg::CONTROL_OFS, 8'h81);
    `CHK("negative pin", 1'b1, ana.neg_sel_pin)
    `CHK("negative gnd off", 1'b0, ana.neg_sel_gnd)
    // Every ladder tap
    for (int l = 0; l < rlc_pkg::TAPS; l++) begin
      wr(rlc_pkg::LEVEL_OFS, l[7:0]);
      `CHK("tap select", 32'h00000001 << l, ana.tap_sel)
    end
    wr(rlc_pkg::CONTROL_OFS, 8'h8C);
    rd(rlc_pkg::CONTROL_OFS, 8'h8C);
    wr(rlc_pkg::CONTROL_OFS, 8'h00);
    `CHK("power off", 1'b0, ana.ladder_power)
    // Low-power source drop and clamps
    wr(rlc_pkg::LEVEL_OFS, 8'h1F);
    `CHK("no negative clamp", 1'b0, ana.clamp_neg)
    wr(rlc_pkg::CONTROL_OFS, 8'h40);
    `CHK("negative dropped", 1'b0, ana.neg_connect)
    `CHK("positive kept", 1'b1, ana.pos_connect)
    `CHK("positive clamp", 1'b1, ana.clamp_pos)
    wr(rlc_pkg::LEVEL_OFS, 8'h1E);
    `CHK("no positive clamp", 1'b0, ana.clamp_pos)
    wr(rlc_pkg::CONTROL_OFS, 8'h00);
    wr(rlc_pkg::LEVEL_OFS, 8'h00);
    `CHK("positive dropped", 1'b0, ana.pos_connect)
    `CHK("negative clamp", 1'b1, ana.clamp_neg)
    // Pin as ordinary digital pin
    cyc(4);
    `CHK("pad drive", 1'b0, pad_oe_n)
    `CHK("pad data", 1'b1, pad_out)
    `CHK("pin read high", 1'b1, port_read)
    @(posedge clock);
    pad_in <= 1'b0;
    cyc(4);
    `CHK("pin read low", 1'b0, port_read)
    @(posedge clock);
    pad_in <= 1'b1;
    cyc(4);
    // Pin routed to the ladder overrides the port
    wr(rlc_pkg::CONTROL_OFS, 8'h20);
    `CHK("pin route", 1'b1, ana.pin_route)
    cyc(1);
    `CHK("pad released", 1'b1, pad_oe_n)
    `CHK("pad data low", 1'b0, pad_out)
    `CHK("routed read", 1'b0, port_read)
    cyc(4);
    `CHK("routed read held", 1'b0, port_read)
    // Sleep and wake keep the control register
    wr(rlc_pkg::CONTROL_OFS, 8'h25);
    @(posedge clock);
    sleep_active <= 1'b1;
    cyc(5);
    @(posedge clock);
    sleep_active <= 1'b0;
    rd(rlc_pkg::CONTROL_OFS, 8'h25);
    // Reset in mid-run
    wr(rlc_pkg::CONTROL_OFS, 8'hA5);
    wr(rlc_pkg::LEVEL_OFS, 8'h15);
    @(posedge clock);
    resetn <= 1'b0;
    cyc(2);
    `CHK("reset power", 1'b0, ana.ladder_power)
    `CHK("reset route", 1'b0, ana.pin_route)
    `CHK("reset pad", 1'b1, pad_oe_n)
    @(posedge clock);
    resetn <= 1'b1;
    rd(rlc_pkg::LEVEL_OFS, 8'h00);
    rd(rlc_pkg::CONTROL_OFS, 8'h00);
    tally_and_finish();
  end

endmodule
